// ===== ofpm_agc_model.sv
// Gain control model counting over-range events on the flag pins
`timescale 1ns/1ps
module ofpm_agc_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Flag pins
   input  wire logic       flag_a,
   input  wire logic       flag_b,
   // Attenuation steps taken
   output logic [7:0]      steps_a,
   output logic [7:0]      steps_b
);
   logic flag_a_q;
   logic flag_b_q;
   // One attenuation step per new over-range event
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_a_q <= 1'b0;
         flag_b_q <= 1'b0;
         steps_a  <= 8'h00;
         steps_b  <= 8'h00;
      end else begin
         flag_a_q <= flag_a;
         flag_b_q <= flag_b;
         steps_a  <= steps_a + 8'(flag_a && !flag_a_q);
         steps_b  <= steps_b + 8'(flag_b && !flag_b_q);
      end
   end
endmodule

// ===== ofpm_ovr_det.sv
// Per-channel over-range comparator with dwell and force
`timescale 1ns/1ps
module ofpm_ovr_det
   import ofpm_pkg::*;
#(
   parameter int SMP_W = 12
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   // Converter samples
   input  wire logic signed [SMP_W-1:0] sample,
   // Settings
   input  wire logic [ofpm_pkg::THR_W-1:0]   upper,
   input  wire logic [ofpm_pkg::THR_W-1:0]   lower,
   input  wire logic [ofpm_pkg::DWELL_W-1:0] dwell,
   input  wire logic                    flag_en,
   input  wire logic                    force_on,
   input  wire logic                    force_val,
   // Results
   output logic [ofpm_pkg::THR_W-1:0]   mag,
   output logic                         flag_q
);
   logic                 det_q;
   logic [DWELL_W-1:0]   dwell_cnt_q;
   logic [SMP_W-1:0]     abs_v;

   // Absolute magnitude, widened to threshold width
   always_comb begin
      abs_v = sample[SMP_W-1] ? SMP_W'(-sample) : SMP_W'(sample);
      mag   = THR_W'(abs_v);
   end

   // Set above upper, clear after dwell below lower
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         det_q       <= 1'b0;
         dwell_cnt_q <= '0;
      end else if (mag > upper) begin
         det_q       <= 1'b1;
         dwell_cnt_q <= '0;
      end else if (det_q && (mag < lower)) begin
         if (dwell_cnt_q >= dwell) begin
            det_q       <= 1'b0;
            dwell_cnt_q <= '0;
         end else begin
            dwell_cnt_q <= dwell_cnt_q + 1'b1;
         end
      end else begin
         dwell_cnt_q <= '0;
      end
   end

   // Pin level: forced value only while force is on
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else if (force_on) begin
         flag_q <= force_val;
      end else begin
         flag_q <= flag_en & det_q;
      end
   end
endmodule

// ===== ofpm_pkg.sv
// Constants for the over-range flag and peak monitor block
package ofpm_pkg;
   // ****************************************
   // Serial port framing
   // ****************************************
   localparam int          SPI_BITS      = 24;
   localparam int          SPI_ADDR_BITS = 16;
   localparam logic [4:0]  SPI_LAST_BIT  = 5'h17;
   localparam logic [4:0]  SPI_ADDR_DONE = 5'h0F;
   localparam int          SPI_RW_POS    = 14;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [14:0] OFS_FLAG_CTRL  = 15'h0245;
   localparam logic [14:0] OFS_UPPER_LO   = 15'h0247;
   localparam logic [14:0] OFS_UPPER_HI   = 15'h0248;
   localparam logic [14:0] OFS_LOWER_LO   = 15'h0249;
   localparam logic [14:0] OFS_LOWER_HI   = 15'h024A;
   localparam logic [14:0] OFS_DWELL_LO   = 15'h024B;
   localparam logic [14:0] OFS_DWELL_HI   = 15'h024C;
   localparam logic [14:0] OFS_MON_SYNC   = 15'h026F;
   localparam logic [14:0] OFS_MON_CTRL   = 15'h0270;
   localparam logic [14:0] OFS_PERIOD_B0  = 15'h0271;
   localparam logic [14:0] OFS_PERIOD_B1  = 15'h0272;
   localparam logic [14:0] OFS_PERIOD_B2  = 15'h0273;
   localparam logic [14:0] OFS_RES_CTRL   = 15'h0274;
   localparam logic [14:0] OFS_RESULT_B0  = 15'h0275;
   localparam logic [14:0] OFS_RESULT_B1  = 15'h0276;
   localparam logic [14:0] OFS_RESULT_B2  = 15'h0277;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int          FLD_FLAG_EN    = 0;
   localparam int          FLD_FORCE_VAL  = 2;
   localparam int          FLD_FORCE      = 3;
   localparam int          FLD_PEAK_EN    = 1;
   localparam int          FLD_RES_SEL    = 0;
   localparam int          FLD_RES_UPD    = 4;
   localparam int          RES_PAD_BITS   = 7;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int          THR_W          = 13;
   localparam int          DWELL_W        = 16;
   localparam int          PERIOD_W       = 24;
   localparam int          RESULT_W       = 20;
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_PERIOD_B0  = 8'h80;
   localparam logic        RST_RES_SEL    = 1'b1;
endpackage

// ===== ofpm_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ofpm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// ===== ofpm_top.sv
// Over-range flags, peak monitor and serial control port
`timescale 1ns/1ps
// Functional notes
// - Force bit drives both flags with value
// - Force value ignored while force is off
// - Peak detector runs only when enabled
// - Result select one picks peak; resets one
// - Peak magnitude lands in result bits 19:7
// - Result bits 6:0 read as zero
// - Result bytes read-only, writes ignored
module ofpm_top
   import ofpm_pkg::*;
#(
   parameter int SMP_W = 12
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   // Converter samples, one per decimated clock
   input  wire logic signed [SMP_W-1:0] sample_a,
   input  wire logic signed [SMP_W-1:0] sample_b,
   // Serial control port pins
   input  wire logic                    spi_csn,
   input  wire logic                    spi_sclk,
   input  wire logic                    spi_sdio_in,
   output logic                         spi_sdio_out,
   output logic                         spi_sdio_oen,
   // Over-range flag pins
   output logic                         overrange_flag_pin_a,
   output logic                         overrange_flag_pin_b
);
   import ofpm_pkg::*;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   // Synchronised pins and detected serial clock edges
   logic [2:0]              pins_s;
   logic                    csn_s;
   logic                    sclk_s;
   logic                    sdi_s;
   logic                    sclk_prev_q;
   logic                    sclk_rise;
   logic                    sclk_fall;

   // Chip select travels inverted, so the cleared synchroniser
   // reads as deselected in the cycles just after reset
   ofpm_sync #(.W(3)) u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .din     ({!spi_csn, spi_sclk, spi_sdio_in}),
      .dout    (pins_s)
   );

   // Synchronised chip select, serial clock and data in
   assign csn_s  = !pins_s[2];
   assign sclk_s = pins_s[1];
   assign sdi_s  = pins_s[0];

   // Clock edge detection on synchronised level
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   // Edges count only inside a frame; falls launch read data
   assign sclk_rise = !csn_s && sclk_s && !sclk_prev_q;
   assign sclk_fall = !csn_s && !sclk_s && sclk_prev_q;

   // ****************************************
   // Serial frame decode
   // ****************************************
   // Frame position, input shifter and read shifter
   logic [4:0]              bit_cnt_q;
   logic [SPI_BITS-2:0]     shift_q;
   logic                    rd_q;
   logic                    in_data_q;
   logic [14:0]             addr_q;
   logic [7:0]              rdata_q;
   logic [7:0]              rd_mux;
   logic [14:0]             addr_w;
   logic [7:0]              wdata_w;
   logic                    wr_stb;

   // Address and data as they complete on the detected rise
   // A write lands only on the last rise, so a cut frame writes nothing
   assign addr_w  = {shift_q[13:0], sdi_s};
   assign wdata_w = {shift_q[6:0], sdi_s};
   assign wr_stb  = sclk_rise && (bit_cnt_q == SPI_LAST_BIT) && !rd_q;

   // Bit counter and input shifter
   // Chip select high drops a cut frame and restarts the count
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q <= '0;
         shift_q   <= '0;
         rd_q      <= 1'b0;
         in_data_q <= 1'b0;
         addr_q    <= '0;
      end else if (csn_s) begin
         bit_cnt_q <= '0;
         in_data_q <= 1'b0;
      end else if (sclk_rise) begin
         shift_q   <= {shift_q[SPI_BITS-3:0], sdi_s};
         bit_cnt_q <= (bit_cnt_q == SPI_LAST_BIT) ? '0 : bit_cnt_q + 1'b1;
         if (bit_cnt_q == SPI_ADDR_DONE) begin
            rd_q      <= shift_q[SPI_RW_POS];
            addr_q    <= addr_w;
            in_data_q <= 1'b1;
         end else if (bit_cnt_q == SPI_LAST_BIT) begin
            in_data_q <= 1'b0;
         end
      end
   end

   // Read data load after address, shifted out on falling edges
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q      <= '0;
         spi_sdio_out <= 1'b0;
      end else if (sclk_rise && (bit_cnt_q == SPI_ADDR_DONE)) begin
         rdata_q <= rd_mux;
      end else if (sclk_fall && in_data_q && rd_q) begin
         spi_sdio_out <= rdata_q[7];
         rdata_q      <= {rdata_q[6:0], 1'b0};
      end
   end

   // Drive the data line only during a read data phase
   assign spi_sdio_oen = !(in_data_q && rd_q && !csn_s);

   // ****************************************
   // Control registers
   // ****************************************
   // Flag settings shared by both channels, then peak monitor settings
   logic                    flag_en_q;
   logic                    force_on_q;
   logic                    force_val_q;
   logic [THR_W-1:0]        upper_q;
   logic [THR_W-1:0]        lower_q;
   logic [DWELL_W-1:0]      dwell_q;
   logic [1:0]              mon_sync_q;
   logic                    peak_en_q;
   logic [PERIOD_W-1:0]     period_q;
   logic                    res_sel_q;

   // Register writes from the serial port
   // Reserved bits are dropped; result bytes ignore writes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_en_q   <= 1'b0;
         force_on_q  <= 1'b0;
         force_val_q <= 1'b0;
         upper_q     <= '0;
         lower_q     <= '0;
         dwell_q     <= '0;
         mon_sync_q  <= '0;
         peak_en_q   <= 1'b0;
         period_q    <= {RST_ZERO, RST_ZERO, RST_PERIOD_B0};
         res_sel_q   <= RST_RES_SEL;
      end else if (wr_stb) begin
         unique case (addr_q)
            OFS_FLAG_CTRL: begin
               flag_en_q   <= wdata_w[FLD_FLAG_EN];
               force_on_q  <= wdata_w[FLD_FORCE];
               force_val_q <= wdata_w[FLD_FORCE_VAL];
            end
            OFS_UPPER_LO:  upper_q[7:0]           <= wdata_w;
            OFS_UPPER_HI:  upper_q[THR_W-1:8]     <= wdata_w[THR_W-9:0];
            OFS_LOWER_LO:  lower_q[7:0]           <= wdata_w;
            OFS_LOWER_HI:  lower_q[THR_W-1:8]     <= wdata_w[THR_W-9:0];
            OFS_DWELL_LO:  dwell_q[7:0]           <= wdata_w;
            OFS_DWELL_HI:  dwell_q[15:8]          <= wdata_w;
            OFS_MON_SYNC:  mon_sync_q             <= wdata_w[1:0];
            OFS_MON_CTRL:  peak_en_q              <= wdata_w[FLD_PEAK_EN];
            OFS_PERIOD_B0: period_q[7:0]          <= wdata_w;
            OFS_PERIOD_B1: period_q[15:8]         <= wdata_w;
            OFS_PERIOD_B2: period_q[23:16]        <= wdata_w;
            OFS_RES_CTRL:  res_sel_q              <= wdata_w[FLD_RES_SEL];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Over-range detectors
   // ****************************************
   logic [THR_W-1:0]        mag_a;

   // Channel A, whose magnitude also feeds the peak monitor
   ofpm_ovr_det #(.SMP_W(SMP_W)) u_det_a (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .sample    (sample_a),
      .upper     (upper_q),
      .lower     (lower_q),
      .dwell     (dwell_q),
      .flag_en   (flag_en_q),
      .force_on  (force_on_q),
      .force_val (force_val_q),
      .mag       (mag_a),
      .flag_q    (overrange_flag_pin_a)
   );

   // Channel B, driving its flag pin only
   ofpm_ovr_det #(.SMP_W(SMP_W)) u_det_b (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .sample    (sample_b),
      .upper     (upper_q),
      .lower     (lower_q),
      .dwell     (dwell_q),
      .flag_en   (flag_en_q),
      .force_on  (force_on_q),
      .force_val (force_val_q),
      .mag       (),
      .flag_q    (overrange_flag_pin_b)
   );

   // ****************************************
   // Peak monitor
   // ****************************************
   // Period counter, running peak and last finished period
   logic [PERIOD_W-1:0]     per_cnt_q;
   logic [THR_W-1:0]        peak_q;
   logic [THR_W-1:0]        hold_q;
   logic [THR_W-1:0]        peak_next;
   logic [RESULT_W-1:0]     result_q;
   logic                    upd_stb;

   // Larger of the running peak and the current magnitude
   assign peak_next = (mag_a > peak_q) ? mag_a : peak_q;

   // Period count and running maximum while enabled
   // A period of 0 or 1 both give a one-cycle window
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         per_cnt_q <= '0;
         peak_q    <= '0;
         hold_q    <= '0;
      end else if (!peak_en_q) begin
         per_cnt_q <= '0;
         peak_q    <= '0;
      end else if (per_cnt_q <= PERIOD_W'(1)) begin
         hold_q    <= peak_next;
         peak_q    <= '0;
         per_cnt_q <= period_q;
      end else begin
         peak_q    <= peak_next;
         per_cnt_q <= per_cnt_q - 1'b1;
      end
   end

   // Update bit self-clears: it acts on the write strobe only
   assign upd_stb = wr_stb && (addr_q == OFS_RES_CTRL) && wdata_w[FLD_RES_UPD];

   // Result snapshot on self-clearing update
   // Select zero is reserved and gives an all-zero result
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         result_q <= '0;
      end else if (upd_stb) begin
         if (wdata_w[FLD_RES_SEL]) begin
            result_q <= {hold_q, RES_PAD_BITS'(0)};
         end else begin
            result_q <= '0;
         end
      end
   end

   // ****************************************
   // Read multiplexer
   // ****************************************
   // Read byte chosen as the last address bit arrives
   // Unmapped places and write-only bits read as zero
   always_comb begin
      rd_mux = RST_ZERO;
      unique case (addr_w)
         OFS_FLAG_CTRL: begin
            rd_mux[FLD_FLAG_EN]   = flag_en_q;
            rd_mux[FLD_FORCE]     = force_on_q;
            rd_mux[FLD_FORCE_VAL] = force_val_q;
         end
         OFS_UPPER_LO:  rd_mux = upper_q[7:0];
         OFS_UPPER_HI:  rd_mux = 8'(upper_q[THR_W-1:8]);
         OFS_LOWER_LO:  rd_mux = lower_q[7:0];
         OFS_LOWER_HI:  rd_mux = 8'(lower_q[THR_W-1:8]);
         OFS_DWELL_LO:  rd_mux = dwell_q[7:0];
         OFS_DWELL_HI:  rd_mux = dwell_q[15:8];
         OFS_MON_SYNC:  rd_mux = 8'(mon_sync_q);
         OFS_MON_CTRL:  rd_mux[FLD_PEAK_EN] = peak_en_q;
         OFS_PERIOD_B0: rd_mux = period_q[7:0];
         OFS_PERIOD_B1: rd_mux = period_q[15:8];
         OFS_PERIOD_B2: rd_mux = period_q[23:16];
         OFS_RES_CTRL:  rd_mux[FLD_RES_SEL] = res_sel_q;   // Update bit reads 0
         OFS_RESULT_B0: rd_mux = result_q[7:0];
         OFS_RESULT_B1: rd_mux = result_q[15:8];
         OFS_RESULT_B2: rd_mux = 8'(result_q[RESULT_W-1:16]);
         default:       rd_mux = RST_ZERO;
      endcase
   end
endmodule

// ===== ofpm_top_sva.sv
// Port checker for the over-range flags and serial port
`timescale 1ns/1ps
module ofpm_chk #(
   parameter int SMP_W = 12
) (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rstn,
   // Samples and serial pins
   input wire logic signed [SMP_W-1:0] sample_a,
   input wire logic signed [SMP_W-1:0] sample_b,
   input wire logic                    spi_csn,
   input wire logic                    spi_sclk,
   input wire logic                    spi_sdio_in,
   input wire logic                    spi_sdio_out,
   input wire logic                    spi_sdio_oen,
   // Flag pins
   input wire logic                    overrange_flag_pin_a,
   input wire logic                    overrange_flag_pin_b
);
   import ofpm_pkg::*;
   logic              sclk_q;
   logic [4:0]        bit_cnt_q;
   logic [23:0]       shift_q;
   logic [7:0]        ctl_q;
   logic [12:0]       upper_q;
   logic [3:0]        age_q;
   logic [23:0]       frame_w;
   logic signed [12:0] ext_a;
   logic signed [12:0] ext_b;
   logic [12:0]       mag_a;
   logic [12:0]       mag_b;
   logic              cfg_ok;
   // Magnitudes and settled configuration
   assign frame_w = {shift_q[22:0], spi_sdio_in};
   assign ext_a   = 13'(sample_a);
   assign ext_b   = 13'(sample_b);
   assign mag_a   = ext_a[12] ? 13'(-ext_a) : 13'(ext_a);
   assign mag_b   = ext_b[12] ? 13'(-ext_b) : 13'(ext_b);
   assign cfg_ok  = &age_q;
   // Shadow of the flag settings, decoded from write frames
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q    <= 1'b0;
         bit_cnt_q <= 5'h00;
         shift_q   <= 24'h000000;
         ctl_q     <= 8'h00;
         upper_q   <= 13'h0000;
         age_q     <= 4'h0;
      end else begin
         sclk_q <= spi_sclk;
         age_q  <= cfg_ok ? age_q : age_q + 4'h1;
         if (spi_csn) begin
            bit_cnt_q <= 5'h00;
         end else if (spi_sclk && !sclk_q) begin
            shift_q   <= frame_w;
            bit_cnt_q <= (bit_cnt_q == SPI_LAST_BIT) ? 5'h00 : bit_cnt_q + 5'h01;
            if (bit_cnt_q == SPI_LAST_BIT && !frame_w[23]) begin
               age_q <= 4'h0;
               if (frame_w[22:8] == OFS_FLAG_CTRL) ctl_q <= frame_w[7:0];
               if (frame_w[22:8] == OFS_UPPER_LO) upper_q[7:0] <= frame_w[7:0];
               if (frame_w[22:8] == OFS_UPPER_HI) upper_q[12:8] <= frame_w[4:0];
            end
         end
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_force_both_pins:
      assert property (cfg_ok && ctl_q[FLD_FORCE] |-> overrange_flag_pin_a == ctl_q[FLD_FORCE_VAL]
         && overrange_flag_pin_b == ctl_q[FLD_FORCE_VAL]) else $error("forced pins wrong");
   a_force_val_ignored:
      assert property (cfg_ok && !ctl_q[FLD_FORCE] && !ctl_q[FLD_FLAG_EN]
         |-> !overrange_flag_pin_a && !overrange_flag_pin_b) else $error("idle pins not low");
   a_flag_a_sets:
      assert property (cfg_ok && !ctl_q[FLD_FORCE] && ctl_q[FLD_FLAG_EN] && mag_a > upper_q
         |-> ##2 overrange_flag_pin_a) else $error("flag a missed over-range");
   a_flag_b_sets:
      assert property (cfg_ok && !ctl_q[FLD_FORCE] && ctl_q[FLD_FLAG_EN] && mag_b > upper_q
         |-> ##2 overrange_flag_pin_b) else $error("flag b missed over-range");
   a_flag_a_cause:
      assert property (cfg_ok && !ctl_q[FLD_FORCE] && $rose(overrange_flag_pin_a)
         |-> $past(mag_a > upper_q, 2)) else $error("flag a rose without cause");
   a_flag_b_cause:
      assert property (cfg_ok && !ctl_q[FLD_FORCE] && $rose(overrange_flag_pin_b)
         |-> $past(mag_b > upper_q, 2)) else $error("flag b rose without cause");
   a_oen_idle:
      assert property (spi_csn [*5] |-> spi_sdio_oen) else $error("data driven while idle");
   a_oen_read_phase:
      assert property ($fell(spi_sdio_oen) |-> bit_cnt_q == 5'h10 && shift_q[15])
      else $error("data driven outside read phase");
endmodule

bind ofpm_top ofpm_chk #(.SMP_W(SMP_W)) u_chk (
   .sys_clk(sys_clk), .rstn(rstn), .sample_a(sample_a), .sample_b(sample_b),
   .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_sdio_in(spi_sdio_in),
   .spi_sdio_out(spi_sdio_out), .spi_sdio_oen(spi_sdio_oen),
   .overrange_flag_pin_a(overrange_flag_pin_a), .overrange_flag_pin_b(overrange_flag_pin_b)
);

// ===== overrange_flag_and_peak_monitor_bench.sv
// Self-checking bench for the over-range flag and peak monitor block
`timescale 1ns/1ps
module overrange_flag_and_peak_monitor_bench;
   import ofpm_pkg::*;
   localparam logic [19:0] PEAK_RES = 20'h002BD << RES_PAD_BITS;
   logic               sys_clk;
   logic               rstn;
   logic signed [11:0] sample_a;
   logic signed [11:0] sample_b;
   logic               spi_csn;
   logic               spi_sclk;
   logic               spi_sdio_in;
   logic               spi_sdio_out;
   logic               spi_sdio_oen;
   logic               pin_a;
   logic               pin_b;
   logic [7:0]         steps_a;
   logic [7:0]         steps_b;
   int                 err_count;
   int                 n_compared;
   logic [14:0]        regs [13] = '{OFS_FLAG_CTRL, OFS_UPPER_LO, OFS_UPPER_HI, OFS_LOWER_LO,
      OFS_LOWER_HI, OFS_DWELL_LO, OFS_DWELL_HI, OFS_MON_SYNC, OFS_MON_CTRL, OFS_PERIOD_B0,
      OFS_PERIOD_B1, OFS_PERIOD_B2, OFS_RES_CTRL};

   ofpm_top dut (
      .sys_clk(sys_clk), .rstn(rstn), .sample_a(sample_a), .sample_b(sample_b),
      .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_sdio_in(spi_sdio_in),
      .spi_sdio_out(spi_sdio_out), .spi_sdio_oen(spi_sdio_oen),
      .overrange_flag_pin_a(pin_a), .overrange_flag_pin_b(pin_b));
   ofpm_agc_model agc (
      .sys_clk(sys_clk), .rstn(rstn), .flag_a(pin_a), .flag_b(pin_b),
      .steps_a(steps_a), .steps_b(steps_b));

   task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s: expected %h, seen %h", n, e, g);
      end
   endtask
   // One 24-bit frame, bits launched on sclk low and read just before sclk rises
   // An undriven data line reads back inverted, so a missing drive shows
   task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      logic [23:0] fr;
      fr = {r, a, d};
      q = 8'h00;
      @(negedge sys_clk) spi_csn = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sclk = 1'b0;
         spi_sdio_in = fr[i];
         repeat (6) @(negedge sys_clk);
         if (i < 8) q[i] = spi_sdio_oen ? !spi_sdio_out : spi_sdio_out;
         spi_sclk = 1'b1;
         repeat (6) @(negedge sys_clk);
      end
      spi_csn = 1'b1;
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e, input string n);
      logic [7:0] q;
      spi(1'b1, a, 8'h00, q);
      check(n, 24'(e), 24'(q));
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      err_count = 0;
      n_compared = 0;
      rstn = 1'b0;
      spi_csn = 1'b1;
      spi_sclk = 1'b1;
      spi_sdio_in = 1'b0;
      sample_a = 12'h000;
      sample_b = 12'h000;
      repeat (20) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      // Reset values, then an unmapped place
      foreach (regs[i]) rd(regs[i], (regs[i] == OFS_PERIOD_B0) ? RST_PERIOD_B0 :
         (regs[i] == OFS_RES_CTRL) ? 8'h01 : RST_ZERO, "reset value");
      rd(15'h0300, 8'h00, "unmapped read");
      // Peak monitor idle, then running on a negative sample
      sample_a = 12'hD43;
      repeat (300) @(negedge sys_clk);
      wr(OFS_RES_CTRL, 8'h11);
      rd(OFS_RESULT_B1, 8'h00, "idle peak");
      rd(OFS_RES_CTRL, 8'h01, "result control");
      wr(OFS_MON_CTRL, 8'h02);
      repeat (300) @(negedge sys_clk);
      wr(OFS_RES_CTRL, 8'h11);
      rd(OFS_RESULT_B0, PEAK_RES[7:0], "result byte 0");
      rd(OFS_RESULT_B1, PEAK_RES[15:8], "result byte 1");
      rd(OFS_RESULT_B2, 8'(PEAK_RES[19:16]), "result byte 2");
      wr(OFS_RESULT_B0, 8'h3C);
      wr(OFS_RESULT_B1, 8'hC3);
      rd(OFS_RESULT_B0, PEAK_RES[7:0], "written byte 0");
      rd(OFS_RESULT_B1, PEAK_RES[15:8], "written byte 1");
      sample_a = 12'h000;
      // Forcing the pins
      wr(OFS_FLAG_CTRL, 8'h04);
      check("pins force off", 24'h0, 24'({pin_a, pin_b}));
      wr(OFS_FLAG_CTRL, 8'h0C);
      check("pins forced high", 24'h3, 24'({pin_a, pin_b}));
      wr(OFS_FLAG_CTRL, 8'h08);
      check("pins forced low", 24'h0, 24'({pin_a, pin_b}));
      // Detection: upper 256, lower 128, dwell 3
      wr(OFS_UPPER_HI, 8'h01);
      wr(OFS_LOWER_LO, 8'h80);
      wr(OFS_DWELL_LO, 8'h03);
      wr(OFS_FLAG_CTRL, 8'h05);
      check("pins no detect", 24'h0, 24'({pin_a, pin_b}));
      sample_a = 12'h12C;
      sample_b = 12'h800;
      repeat (3) @(negedge sys_clk);
      check("pins over range", 24'h3, 24'({pin_a, pin_b}));
      sample_a = 12'h0C8;
      sample_b = 12'h000;
      repeat (2) @(negedge sys_clk);
      check("flag b in dwell", 24'h3, 24'({pin_a, pin_b}));
      repeat (10) @(negedge sys_clk);
      check("flag b released", 24'h2, 24'({pin_a, pin_b}));
      sample_a = 12'h064;
      repeat (2) @(negedge sys_clk);
      sample_a = 12'h0C8;
      @(negedge sys_clk);
      sample_a = 12'h064;
      repeat (3) @(negedge sys_clk);
      check("flag a restarted", 24'h2, 24'({pin_a, pin_b}));
      repeat (10) @(negedge sys_clk);
      check("flag a released", 24'h0, 24'({pin_a, pin_b}));
      check("gain steps", 24'h0202, 24'({steps_a, steps_b}));
      give_verdict();
   end
endmodule
